/* File: tcoc_pkg.sv */
// Purpose: constants and carriers for the compare output control block
// Assumes: 32-bit APB, one aligned word per register
// Notes:   offsets are byte addresses
package tcoc_pkg;
  localparam int unsigned AW = 8;
  localparam logic [AW-1:0] OFF_CTRL     = 8'h00;
  localparam logic [AW-1:0] OFF_CMP      = 8'h04;
  localparam logic [AW-1:0] OFF_SHARED_A = 8'h08;
  localparam logic [AW-1:0] OFF_SHARED_B = 8'h0C;
  localparam logic [AW-1:0] OFF_SHARED_C = 8'h10;
  localparam logic [AW-1:0] OFF_CAP_D    = 8'h14;
  localparam logic [7:0]    CTRL_RESET   = 8'h00;
  localparam int unsigned   BIT_CAPD_MS  = 7;
  localparam int unsigned   BIT_CMPA_MS  = 6;
  localparam int unsigned   BIT_SHR_SEL  = 5;
  localparam int unsigned   BIT_CMP_SEL  = 4;
  localparam int unsigned   BIT_OE_A     = 3;
  localparam int unsigned   BIT_OE_B     = 2;
  localparam int unsigned   BIT_LVL_A    = 1;
  localparam int unsigned   BIT_LVL_B    = 0;

  typedef struct packed {
    logic capture_d_mode_select;
    logic compare_a_mode_select;
    logic shared_address_select;
    logic compare_reg_select;
    logic compare_a_output_enable;
    logic compare_b_output_enable;
    logic compare_a_output_level;
    logic compare_b_output_level;
  } tcoc_ctrl_s;

  typedef struct packed {
    logic a;
    logic b;
    logic c;
    logic d;
  } tcoc_cap_s;
endpackage

/* File: tcoc_top.sv */
// Purpose: compare output control register, compare pins, capture and compare datapath
// Assumes: counter value and capture strobes come from logic on clk
// Notes:   count_tick marks the last state of a counter value
`timescale 1ns/100ps
module tcoc_top #(
  parameter int unsigned CW = 16
) (
  input  wire logic                   clk,            // system clock
  input  wire logic                   srst,           // synchronous reset
  input  wire logic                   ce,             // clock enable, freezes state
  input  wire logic                   psel,           // apb select
  input  wire logic                   penable,        // apb enable
  input  wire logic                   pwrite,         // apb direction
  input  wire logic [tcoc_pkg::AW-1:0] paddr,         // apb byte address
  input  wire logic [31:0]            pwdata,         // apb write data
  output logic      [31:0]            prdata,         // apb read data
  output logic                        pready,         // apb ready
  output logic                        pslverr,        // apb error, unmapped address
  input  wire logic [CW-1:0]          free_running_counter, // counter value
  input  wire logic                   count_tick,     // counter about to change
  input  wire tcoc_pkg::tcoc_cap_s    capture_strobe, // selected capture edges
  output logic                        compare_a_output_pin,    // pin A level
  output logic                        compare_a_output_pin_oe, // pin A drive enable
  output logic                        compare_b_output_pin,    // pin B level
  output logic                        compare_b_output_pin_oe, // pin B drive enable
  output logic                        capture_d_masked         // mask state
);
  tcoc_pkg::tcoc_ctrl_s ctrl_r, ctrl_nxt;
  logic [CW-1:0] cmp_a_r, cmp_a_nxt, cmp_b_r, cmp_b_nxt;
  logic [CW-1:0] rise_r, rise_nxt, fall_r, fall_nxt, mask_r, mask_nxt;
  logic [CW-1:0] cap_a_r, cap_a_nxt, cap_b_r, cap_b_nxt;
  logic [CW-1:0] cap_c_r, cap_c_nxt, cap_d_r, cap_d_nxt;
  logic [CW-1:0] mask_end_r, mask_end_nxt;
  logic          phase_r, phase_nxt;
  logic          masked_r, masked_nxt;
  logic          pin_a_r, pin_a_nxt, pin_b_r, pin_b_nxt;
  logic          oe_a_r, oe_a_nxt, oe_b_r, oe_b_nxt;
  logic [31:0]   prdata_r, prdata_nxt;
  logic          pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic          acc_done, wr_done, match_a, match_b, cap_d_ev;
  logic          wr_ctrl, wr_cmp, wr_sa, wr_sb, wr_sc;
  logic          mapped;
  logic [31:0]   rd_word;

  // transfer completes at the edge that sees pready high
  assign acc_done = psel && penable && pready_r;
  assign wr_done  = acc_done && pwrite;
  assign wr_ctrl  = wr_done && paddr == tcoc_pkg::OFF_CTRL;
  assign wr_cmp   = wr_done && paddr == tcoc_pkg::OFF_CMP;
  assign wr_sa    = wr_done && paddr == tcoc_pkg::OFF_SHARED_A;
  assign wr_sb    = wr_done && paddr == tcoc_pkg::OFF_SHARED_B;
  assign wr_sc    = wr_done && paddr == tcoc_pkg::OFF_SHARED_C;

  // a write to the compare value wins over a match in the same cycle
  assign match_a = count_tick && free_running_counter == cmp_a_r
                   && !(wr_cmp && !ctrl_r.compare_reg_select);
  assign match_b = count_tick && free_running_counter == cmp_b_r
                   && !(wr_cmp && ctrl_r.compare_reg_select);
  assign cap_d_ev = capture_strobe.d && !masked_r;

  // read mux and decode
  always_comb begin
    mapped  = 1'b1;
    rd_word = 32'h0000_0000;
    case (paddr)
      tcoc_pkg::OFF_CTRL:     rd_word[7:0] = ctrl_r;
      tcoc_pkg::OFF_CMP:      rd_word[CW-1:0] = ctrl_r.compare_reg_select ? cmp_b_r : cmp_a_r;
      tcoc_pkg::OFF_SHARED_A: rd_word[CW-1:0] = ctrl_r.shared_address_select ? rise_r : cap_a_r;
      tcoc_pkg::OFF_SHARED_B: rd_word[CW-1:0] = ctrl_r.shared_address_select ? fall_r : cap_b_r;
      tcoc_pkg::OFF_SHARED_C: rd_word[CW-1:0] = ctrl_r.shared_address_select ? mask_r : cap_c_r;
      tcoc_pkg::OFF_CAP_D:    rd_word[CW-1:0] = cap_d_r;
      default:                mapped = 1'b0;
    endcase
  end

  // bus slave: answer one cycle into the access phase
  always_comb begin
    pready_nxt  = 1'b0;
    prdata_nxt  = prdata_r;
    pslverr_nxt = 1'b0;
    if (psel && penable && !pready_r) begin
      pready_nxt  = 1'b1;
      prdata_nxt  = pwrite ? 32'h0000_0000 : rd_word;
      pslverr_nxt = !mapped;
    end
  end

  // software registers
  always_comb begin
    ctrl_nxt  = ctrl_r;
    cmp_b_nxt = cmp_b_r;
    rise_nxt  = rise_r;
    fall_nxt  = fall_r;
    mask_nxt  = mask_r;
    phase_nxt = phase_r;
    cmp_a_nxt = cmp_a_r;
    if (wr_ctrl) ctrl_nxt = tcoc_pkg::tcoc_ctrl_s'(pwdata[7:0]);
    if (wr_sa && ctrl_r.shared_address_select) rise_nxt = pwdata[CW-1:0];
    if (wr_sb && ctrl_r.shared_address_select) fall_nxt = pwdata[CW-1:0];
    if (wr_sc && ctrl_r.shared_address_select) mask_nxt = pwdata[CW-1:0];
    if (wr_cmp && ctrl_r.compare_reg_select) cmp_b_nxt = pwdata[CW-1:0];
    if (wr_cmp && !ctrl_r.compare_reg_select) begin
      cmp_a_nxt = pwdata[CW-1:0];
    end else if (match_a && ctrl_r.compare_a_mode_select) begin
      // rising step first, then falling step
      cmp_a_nxt = CW'(cmp_a_r + (phase_r ? fall_r : rise_r));
      phase_nxt = !phase_r;
    end
    if (!ctrl_r.compare_a_mode_select) phase_nxt = 1'b0;
  end

  // capture registers A to C follow their strobes whatever the select bits say; D skips strobes while masked in mask mode
  always_comb begin
    cap_a_nxt    = capture_strobe.a ? free_running_counter : cap_a_r;
    cap_b_nxt    = capture_strobe.b ? free_running_counter : cap_b_r;
    cap_c_nxt    = capture_strobe.c ? free_running_counter : cap_c_r;
    cap_d_nxt    = cap_d_ev ? free_running_counter : cap_d_r;
    mask_end_nxt = mask_end_r;
    masked_nxt   = masked_r;
    if (!ctrl_r.capture_d_mode_select || mask_r == '0) begin
      masked_nxt = 1'b0;
    end else if (cap_d_ev) begin
      // window ends at capture plus twice the interval
      masked_nxt   = 1'b1;
      mask_end_nxt = CW'(free_running_counter + {mask_r[CW-2:0], 1'b0});
    end else if (count_tick && free_running_counter == mask_end_r) begin
      masked_nxt = 1'b0;
    end
  end

  // compare pins; in addend mode pin A toggles so steps give high/low times
  always_comb begin
    pin_a_nxt = pin_a_r;
    pin_b_nxt = pin_b_r;
    oe_a_nxt  = ctrl_r.compare_a_output_enable;
    oe_b_nxt  = ctrl_r.compare_b_output_enable;
    if (match_a) begin
      if (ctrl_r.compare_a_mode_select) pin_a_nxt = !phase_r;
      else pin_a_nxt = ctrl_r.compare_a_output_level;
    end
    if (match_b) pin_b_nxt = ctrl_r.compare_b_output_level;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_r     <= tcoc_pkg::tcoc_ctrl_s'(tcoc_pkg::CTRL_RESET);
      cmp_a_r    <= '0;
      cmp_b_r    <= '0;
      rise_r     <= '0;
      fall_r     <= '0;
      mask_r     <= '0;
      cap_a_r    <= '0;
      cap_b_r    <= '0;
      cap_c_r    <= '0;
      cap_d_r    <= '0;
      mask_end_r <= '0;
      phase_r    <= 1'b0;
      masked_r   <= 1'b0;
      pin_a_r    <= 1'b0;
      pin_b_r    <= 1'b0;
      oe_a_r     <= 1'b0;
      oe_b_r     <= 1'b0;
      prdata_r   <= 32'h0000_0000;
      pready_r   <= 1'b0;
      pslverr_r  <= 1'b0;
    end else if (ce) begin
      ctrl_r     <= ctrl_nxt;
      cmp_a_r    <= cmp_a_nxt;
      cmp_b_r    <= cmp_b_nxt;
      rise_r     <= rise_nxt;
      fall_r     <= fall_nxt;
      mask_r     <= mask_nxt;
      cap_a_r    <= cap_a_nxt;
      cap_b_r    <= cap_b_nxt;
      cap_c_r    <= cap_c_nxt;
      cap_d_r    <= cap_d_nxt;
      mask_end_r <= mask_end_nxt;
      phase_r    <= phase_nxt;
      masked_r   <= masked_nxt;
      pin_a_r    <= pin_a_nxt;
      pin_b_r    <= pin_b_nxt;
      oe_a_r     <= oe_a_nxt;
      oe_b_r     <= oe_b_nxt;
      prdata_r   <= prdata_nxt;
      pready_r   <= pready_nxt;
      pslverr_r  <= pslverr_nxt;
    end
  end

  assign prdata                  = prdata_r;
  assign pready                  = pready_r;
  assign pslverr                 = pslverr_r;
  assign compare_a_output_pin    = pin_a_r;
  assign compare_a_output_pin_oe = oe_a_r;
  assign compare_b_output_pin    = pin_b_r;
  assign compare_b_output_pin_oe = oe_b_r;
  assign capture_d_masked        = masked_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst || !ce);

  ctrl_reset_a: assert property (@(posedge clk) disable iff (1'b0)
    srst |=> ctrl_r == tcoc_pkg::tcoc_ctrl_s'(tcoc_pkg::CTRL_RESET)) else $error("control not cleared");
  ctrl_write_a: assert property (wr_ctrl |=> ctrl_r == $past(pwdata[7:0]))
    else $error("control write lost");
  oe_a_follow_a: assert property (wr_ctrl ##1 ce |=> oe_a_r == $past(pwdata[tcoc_pkg::BIT_OE_A], 2))
    else $error("pin A enable wrong");
  oe_b_follow_a: assert property (wr_ctrl ##1 ce |=> oe_b_r == $past(pwdata[tcoc_pkg::BIT_OE_B], 2))
    else $error("pin B enable wrong");
  pin_a_level_a: assert property (match_a && !ctrl_r.compare_a_mode_select
    |=> pin_a_r == $past(ctrl_r.compare_a_output_level)) else $error("pin A level wrong");
  pin_a_ignore_a: assert property (match_a && ctrl_r.compare_a_mode_select
    |=> pin_a_r == !$past(phase_r)) else $error("pin A level bit not ignored");
  pin_b_level_a: assert property (match_b |=> pin_b_r == $past(ctrl_r.compare_b_output_level))
    else $error("pin B level wrong");
  addend_step_a: assert property (match_a && ctrl_r.compare_a_mode_select && !wr_cmp
    |=> cmp_a_r == CW'($past(cmp_a_r) + ($past(phase_r) ? $past(fall_r) : $past(rise_r))))
    else $error("addend step wrong");
  cmp_match_b_a: assert property (count_tick && free_running_counter == cmp_b_r && !wr_cmp
    |=> pin_b_r == $past(ctrl_r.compare_b_output_level)) else $error("match B lost");
  cap_a_keep_a: assert property (capture_strobe.a |=> cap_a_r == $past(free_running_counter))
    else $error("capture A lost");
  mask_block_a: assert property (masked_r && capture_strobe.d |=> cap_d_r == $past(cap_d_r))
    else $error("masked capture taken");
  mask_mode_a: assert property (!ctrl_r.capture_d_mode_select |=> !masked_r)
    else $error("mask outside mode");
  shared_rd_a: assert property (psel && penable && !pready_r && !pwrite
    && paddr == tcoc_pkg::OFF_SHARED_A && ctrl_r.shared_address_select
    |=> prdata_r[CW-1:0] == $past(rise_r)) else $error("shared read misrouted");
  cmp_rd_a: assert property (psel && penable && !pready_r && !pwrite
    && paddr == tcoc_pkg::OFF_CMP && ctrl_r.compare_reg_select
    |=> prdata_r[CW-1:0] == $past(cmp_b_r)) else $error("compare read misrouted");
  mode_a_a: assert property (wr_ctrl && !pwdata[tcoc_pkg::BIT_CMPA_MS] |=> !ctrl_r.compare_a_mode_select)
    else $error("mode A not cleared");

  // hold, read, write, pin, mask and capture checks: a state that nothing touches must not drift
  ctrl_hold_a: assert property (!wr_ctrl |=> ctrl_r == $past(ctrl_r))
    else $error("control changed without write");
  ctrl_read_a: assert property (psel && penable && !pready_r && !pwrite && paddr == tcoc_pkg::OFF_CTRL
    |=> prdata_r[7:0] == $past(ctrl_r)) else $error("control read wrong");
  freeze_a: assert property (@(posedge clk) disable iff (srst) !ce
    |=> ctrl_r == $past(ctrl_r) && pin_a_r == $past(pin_a_r) && prdata_r == $past(prdata_r)) else $error("state moved");
  ready_once_a: assert property (pready_r |=> !pready_r)
    else $error("ready longer than one cycle");
  cmp_a_rd_a: assert property (psel && penable && !pready_r && !pwrite
    && paddr == tcoc_pkg::OFF_CMP && !ctrl_r.compare_reg_select
    |=> prdata_r[CW-1:0] == $past(cmp_a_r)) else $error("compare A read misrouted");
  cmp_a_wr_a: assert property (wr_cmp && !ctrl_r.compare_reg_select |=> cmp_a_r == $past(pwdata[CW-1:0]))
    else $error("compare A write lost");
  cmp_b_wr_a: assert property (wr_cmp && ctrl_r.compare_reg_select |=> cmp_b_r == $past(pwdata[CW-1:0]))
    else $error("compare B write lost");
  cmp_b_keep_a: assert property (wr_cmp && !ctrl_r.compare_reg_select |=> cmp_b_r == $past(cmp_b_r))
    else $error("compare B hit by A write");
  rise_wr_a: assert property (wr_sa && ctrl_r.shared_address_select |=> rise_r == $past(pwdata[CW-1:0]))
    else $error("rising addend write lost");
  fall_wr_a: assert property (wr_sb && ctrl_r.shared_address_select |=> fall_r == $past(pwdata[CW-1:0]))
    else $error("falling addend write lost");
  mask_wr_a: assert property (wr_sc && ctrl_r.shared_address_select |=> mask_r == $past(pwdata[CW-1:0]))
    else $error("mask interval write lost");
  fall_rd_a: assert property (psel && penable && !pready_r && !pwrite
    && paddr == tcoc_pkg::OFF_SHARED_B && ctrl_r.shared_address_select
    |=> prdata_r[CW-1:0] == $past(fall_r)) else $error("falling addend read misrouted");
  cap_a_rd_a: assert property (psel && penable && !pready_r && !pwrite
    && paddr == tcoc_pkg::OFF_SHARED_A && !ctrl_r.shared_address_select
    |=> prdata_r[CW-1:0] == $past(cap_a_r)) else $error("capture A read misrouted");
  rise_keep_a: assert property (wr_sa && !ctrl_r.shared_address_select |=> rise_r == $past(rise_r))
    else $error("rising addend hit by capture write");
  cap_b_keep_a: assert property (capture_strobe.b |=> cap_b_r == $past(free_running_counter))
    else $error("capture B lost");
  cap_c_keep_a: assert property (capture_strobe.c |=> cap_c_r == $past(free_running_counter))
    else $error("capture C lost");
  cmp_match_a_a: assert property (count_tick && free_running_counter == cmp_a_r && !wr_cmp
    && !ctrl_r.compare_a_mode_select |=> pin_a_r == $past(ctrl_r.compare_a_output_level)) else $error("match A lost");
  oe_a_off_a: assert property (!ctrl_r.compare_a_output_enable |=> !oe_a_r)
    else $error("pin A driven while disabled");
  oe_b_off_a: assert property (!ctrl_r.compare_b_output_enable |=> !oe_b_r)
    else $error("pin B driven while disabled");
  pin_a_hold_a: assert property (!match_a |=> pin_a_r == $past(pin_a_r))
    else $error("pin A moved without match");
  pin_b_hold_a: assert property (!match_b |=> pin_b_r == $past(pin_b_r))
    else $error("pin B moved without match");
  phase_clr_a: assert property (!ctrl_r.compare_a_mode_select |=> !phase_r)
    else $error("phase kept outside addend mode");
  cmp_a_normal_a: assert property (match_a && !ctrl_r.compare_a_mode_select |=> cmp_a_r == $past(cmp_a_r))
    else $error("compare A moved in normal mode");
  mask_set_a: assert property (ctrl_r.capture_d_mode_select && mask_r != '0 && cap_d_ev |=> masked_r)
    else $error("mask not set");
  mask_zero_a: assert property (mask_r == '0 |=> !masked_r)
    else $error("mask with zero interval");
  cap_d_take_a: assert property (cap_d_ev |=> cap_d_r == $past(free_running_counter))
    else $error("capture D lost");
endmodule

/* File: tcoc_top_tb.sv */
// Purpose: self-checking bench for the compare output control block
// Assumes: one wait state apb slave, registered pins, ce held high except during the pin A freeze check
// Notes:   short apb tasks; each test is a call sequence with expected values
`timescale 1ns/100ps
module tcoc_top_tb;
  logic                    clk = 1'b0;
  logic                    srst = 1'b1;
  logic                    ce = 1'b1;
  logic                    psel = 1'b0;
  logic                    penable = 1'b0;
  logic                    pwrite = 1'b0;
  logic [tcoc_pkg::AW-1:0] paddr = 8'h00;
  logic [31:0]             pwdata = 32'h0000_0000;
  logic [31:0]             prdata;
  logic                    pready;
  logic                    pslverr;
  logic [15:0]             free_running_counter = 16'h0000;
  logic                    count_tick = 1'b0;
  tcoc_pkg::tcoc_cap_s     capture_strobe = 4'h0;
  logic                    pin_a, oe_a, pin_b, oe_b, masked;
  logic [31:0]             rd;
  logic                    er;
  int                      num_errors = 0;
  int                      num_checks = 0;

  tcoc_top #(.CW(16)) u_dut (
    .clk(clk), .srst(srst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .free_running_counter(free_running_counter), .count_tick(count_tick),
    .capture_strobe(capture_strobe), .compare_a_output_pin(pin_a), .compare_a_output_pin_oe(oe_a),
    .compare_b_output_pin(pin_b), .compare_b_output_pin_oe(oe_b), .capture_d_masked(masked));

  always #25 clk = ~clk;

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk_w(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_b(input string what, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %b seen %b", what, exp, got);
    end
  endtask

  // one transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      num_errors++;
      $display("unexpected pready: expected 1 seen timeout");
      end_of_test();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk_w(what, exp, rd);
  endtask

  // counter value with optional tick and capture strobes for one cycle
  task automatic ev(input logic [15:0] c, input logic t, input logic [3:0] s);
    @(posedge clk);
    free_running_counter <= c; count_tick <= t; capture_strobe <= s;
    @(posedge clk);
    count_tick <= 1'b0; capture_strobe <= 4'h0;
    @(negedge clk);
  endtask

  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    rdc("ctrl reset", 8'h00, 32'h0000_0000);
    wr(8'h00, 32'h0000_00A5);
    rdc("ctrl a5", 8'h00, 32'h0000_00A5);
    wr(8'h00, 32'h0000_005A);
    rdc("ctrl 5a", 8'h00, 32'h0000_005A);
    apb(1'b0, 8'h18, 32'h0000_0000);
    chk_b("unmapped err", 1'b1, er);
    chk_w("unmapped data", 32'h0000_0000, rd);
    $display("test register access done");
    wr(8'h00, 32'h0000_000C);
    repeat (3) @(posedge clk);
    chk_b("oe a on", 1'b1, oe_a);
    chk_b("oe b on", 1'b1, oe_b);
    wr(8'h00, 32'h0000_0000);
    repeat (3) @(posedge clk);
    chk_b("oe a off", 1'b0, oe_a);
    chk_b("oe b off", 1'b0, oe_b);
    $display("test output enable done");
    wr(8'h04, 32'h0000_0010);
    wr(8'h00, 32'h0000_0010);
    wr(8'h04, 32'h0000_0020);
    rdc("cmp b", 8'h04, 32'h0000_0020);
    wr(8'h00, 32'h0000_000F);
    rdc("cmp a", 8'h04, 32'h0000_0010);
    ev(16'h0010, 1'b1, 4'h0);
    chk_b("pin a high", 1'b1, pin_a);
    chk_b("pin b idle", 1'b0, pin_b);
    ev(16'h0020, 1'b1, 4'h0);
    chk_b("pin b high", 1'b1, pin_b);
    wr(8'h00, 32'h0000_001C);
    ev(16'h0010, 1'b1, 4'h0);
    chk_b("pin a low", 1'b0, pin_a);
    ev(16'h0020, 1'b1, 4'h0);
    chk_b("pin b low", 1'b0, pin_b);
    wr(8'h00, 32'h0000_000F);
    @(posedge clk) ce <= 1'b0;
    ev(16'h0010, 1'b1, 4'h0);
    chk_b("pin a frozen", 1'b0, pin_a);
    @(posedge clk) ce <= 1'b1;
    $display("test compare match done");
    wr(8'h00, 32'h0000_0000);
    ev(16'h1234, 1'b0, 4'h9);
    rdc("cap a", 8'h08, 32'h0000_1234);
    rdc("cap d", 8'h14, 32'h0000_1234);
    chk_b("no mask", 1'b0, masked);
    wr(8'h08, 32'h0000_5555);
    rdc("cap a ro", 8'h08, 32'h0000_1234);
    wr(8'h00, 32'h0000_0020);
    wr(8'h08, 32'h0000_0003);
    wr(8'h0C, 32'h0000_0005);
    rdc("rise add", 8'h08, 32'h0000_0003);
    rdc("fall add", 8'h0C, 32'h0000_0005);
    ev(16'h4321, 1'b0, 4'h8);
    wr(8'h00, 32'h0000_0000);
    rdc("cap a live", 8'h08, 32'h0000_4321);
    $display("test shared address done");
    wr(8'h00, 32'h0000_0048);
    wr(8'h04, 32'h0000_0100);
    ev(16'h0100, 1'b1, 4'h0);
    chk_b("add pin a 1", 1'b1, pin_a);
    rdc("cmp a rise", 8'h04, 32'h0000_0103);
    ev(16'h0103, 1'b1, 4'h0);
    chk_b("add pin a 0", 1'b0, pin_a);
    rdc("cmp a fall", 8'h04, 32'h0000_0108);
    $display("test addend mode done");
    wr(8'h00, 32'h0000_00A0);
    wr(8'h10, 32'h0000_0004);
    rdc("mask int", 8'h10, 32'h0000_0004);
    ev(16'h0200, 1'b0, 4'h1);
    chk_b("mask set", 1'b1, masked);
    rdc("cap d first", 8'h14, 32'h0000_0200);
    ev(16'h0205, 1'b0, 4'h1);
    rdc("cap d held", 8'h14, 32'h0000_0200);
    ev(16'h0208, 1'b1, 4'h0);
    chk_b("mask clear", 1'b0, masked);
    ev(16'h0209, 1'b0, 4'h1);
    rdc("cap d again", 8'h14, 32'h0000_0209);
    chk_b("mask before reset", 1'b1, masked);
    $display("test mask mode done");
    @(posedge clk) srst <= 1'b1;
    @(posedge clk) srst <= 1'b0;
    rdc("ctrl after reset", 8'h00, 32'h0000_0000);
    chk_b("mask after reset", 1'b0, masked);
    $display("test mid-run reset done");
    end_of_test();
  end
endmodule
